// ==== src/rcf_reset_cause_flags.sv ====
/*
 Top of the reset cause flag block and the upper control register map
 of the clock, reset and power unit, reached over Avalon-MM.
 Assumes cause inputs are synchronous levels from the reset detectors
 and that power-on reset is asserted before the first access.
*/
// The Avalon-MM interface to the registers was left to the implementer.
module rcf_reset_cause_flags (
  input wire logic clk_sys, // System clock, 250 MHz
  input wire logic nrst, // System reset, synchronous, active low
  input wire rcf_pkg::rcf_cause_s causeIn, // Reset cause levels
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic [1:0] avs_response, // Access response
  output logic avs_waitrequest, // Wait request
  output logic [7:0] resetFlags, // Current cause flags
  output rcf_pkg::rcf_map_t mapRegs, // Control registers
  output rcf_pkg::rcf_arm_s armKey // Watchdog arm key write
);
  import rcf_pkg::*;

  logic [5:0] regIdx;
  logic [3:0] mapSlot;
  logic inMap;
  logic mapped;
  logic lowLane;
  logic wrFire;
  logic protectOn;
  logic mapWrite;
  logic flagWrite;
  logic armWrite;
  logic [7:0] wrByte;
  logic [7:0] wrMask;
  logic [7:0] mapRead;
  logic [31:0] rdValue;
  logic [7:0] flagsVal;
  rcf_map_t map_ff;
  rcf_map_t nxt_map;
  rcf_arm_s arm_ff;
  rcf_arm_s nxt_arm;

  // Word index and slot inside the upper map
  assign regIdx = avs_address[7:2];
  assign mapSlot = regIdx[3:0];
  assign inMap = (regIdx >= IDX_HT_CTL) && (regIdx <= IDX_RSVD_1F);
  assign mapped = (regIdx == IDX_FLAGS) || (regIdx == IDX_ARM_KEY) ||
    inMap;

  // Only the low byte lane carries register data
  assign lowLane = avs_byteenable[0];
  assign wrByte = avs_writedata[7:0];
  assign wrMask = rcf_wr_mask(regIdx);

  // Protect bit steers which writes land
  assign protectOn = map_ff[IDX_PROTECT[3:0]][BIT_WRITE_PROTECT];

  // Write qualifiers per target
  always_comb begin
    flagWrite = wrFire && lowLane && (regIdx == IDX_FLAGS);
    armWrite = wrFire && lowLane && (regIdx == IDX_ARM_KEY);
    mapWrite = wrFire && lowLane && inMap &&
      !(protectOn && rcf_is_locked(regIdx));
  end

  // Bus handshake and registered answer
  rcf_avmm_slave u_slave (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .rdValue(rdValue),
    .rdError(!mapped),
    .wrFire(wrFire),
    .avs_readdata(avs_readdata),
    .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest)
  );

  // Reset cause flag register
  rcf_cause_flags u_flags (
    .clk_sys(clk_sys),
    .causeIn(causeIn),
    .clrWr(flagWrite),
    .clrData(wrByte),
    .flags_ff(flagsVal)
  );

  assign resetFlags = flagsVal;

  // Next map value: only writable bits of the addressed slot move
  always_comb begin
    nxt_map = map_ff;
    if (mapWrite) begin
      nxt_map[mapSlot] = (map_ff[mapSlot] & ~wrMask) | (wrByte & wrMask);
    end
  end

  // Control register storage, cleared by system reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      map_ff <= {RCF_MAP_DEPTH{MAP_RESET_VALUE}};
    end else begin
      map_ff <= nxt_map;
    end
  end

  assign mapRegs = map_ff;

  // Arm key write becomes a one-cycle strobe with its byte
  always_comb begin
    nxt_arm.strobe = armWrite;
    nxt_arm.key = armWrite ? wrByte : arm_ff.key;
  end

  // Arm key output register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      arm_ff <= '0;
    end else begin
      arm_ff <= nxt_arm;
    end
  end

  assign armKey = arm_ff;

  // Map read with bits outside the write mask forced to zero
  assign mapRead = map_ff[mapSlot] & wrMask;

  // Read mux; unmapped words answer zero
  always_comb begin
    rdValue = '0;
    if (regIdx == IDX_FLAGS) begin
      rdValue[7:0] = flagsVal & FLAG_IMPL_MASK;
    end else if (inMap) begin
      rdValue[7:0] = mapRead;
    end
  end

endmodule

// ==== src/rcf_pkg.sv ====
/*
 Constants, types and decode helpers for the reset cause flag block
 and the upper control register map of the clock and power unit.
 Assumes a single 250 MHz clock domain and 32-bit Avalon-MM access.
*/
package rcf_pkg;

  localparam int RCF_ADDR_W = 8;
  localparam int RCF_DATA_W = 32;
  localparam int RCF_MAP_DEPTH = 16;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_FLAGS = 6'h03;
  localparam logic [5:0] IDX_ARM_KEY = 6'h0f;
  localparam logic [5:0] IDX_HT_CTL = 6'h10;
  localparam logic [5:0] IDX_LV_CTL = 6'h11;
  localparam logic [5:0] IDX_API_CTL = 6'h12;
  localparam logic [5:0] IDX_ACLK_TRIM = 6'h13;
  localparam logic [5:0] IDX_API_HIGH = 6'h14;
  localparam logic [5:0] IDX_API_LOW = 6'h15;
  localparam logic [5:0] IDX_TEST_THREE = 6'h16;
  localparam logic [5:0] IDX_HT_TRIM = 6'h17;
  localparam logic [5:0] IDX_IRC_HIGH = 6'h18;
  localparam logic [5:0] IDX_IRC_LOW = 6'h19;
  localparam logic [5:0] IDX_OSC_CTL = 6'h1a;
  localparam logic [5:0] IDX_PROTECT = 6'h1b;
  localparam logic [5:0] IDX_TEST_TWO = 6'h1c;
  localparam logic [5:0] IDX_VREG_CTL = 6'h1d;
  localparam logic [5:0] IDX_OSC_CTL_TWO = 6'h1e;
  localparam logic [5:0] IDX_RSVD_1F = 6'h1f;

  // Flag field positions and values
  localparam int BIT_POR = 6;
  localparam int BIT_LOW_VOLT = 5;
  localparam int BIT_WATCHDOG = 3;
  localparam int BIT_OSC_LOSS = 1;
  localparam int BIT_PLL_LOSS = 0;
  localparam logic [7:0] FLAG_IMPL_MASK = 8'h6b;
  localparam logic [7:0] FLAG_POR_VALUE = 8'h60;

  localparam int BIT_WRITE_PROTECT = 0;
  localparam logic [7:0] MAP_RESET_VALUE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [RCF_MAP_DEPTH-1:0][7:0] rcf_map_t;

  // Reset cause levels from the unit's detectors
  typedef struct packed {
    logic por;
    logic lowVoltCore;
    logic lowVoltNvm;
    logic lowVoltPad;
    logic watchdog;
    logic oscLoss;
    logic pllLoss;
  } rcf_cause_s;

  // Watchdog arm key write towards the watchdog logic
  typedef struct packed {
    logic strobe;
    logic [7:0] key;
  } rcf_arm_s;

  // Writable bits of each map register; zero marks reserved slots
  function automatic logic [7:0] rcf_wr_mask(input logic [5:0] idx);
    case (idx)
      IDX_HT_CTL: rcf_wr_mask = 8'h2a;
      IDX_LV_CTL: rcf_wr_mask = 8'h02;
      IDX_API_CTL: rcf_wr_mask = 8'h9e;
      IDX_ACLK_TRIM: rcf_wr_mask = 8'hfc;
      IDX_API_HIGH: rcf_wr_mask = 8'hff;
      IDX_API_LOW: rcf_wr_mask = 8'hff;
      IDX_HT_TRIM: rcf_wr_mask = 8'h8f;
      IDX_IRC_HIGH: rcf_wr_mask = 8'hfb;
      IDX_IRC_LOW: rcf_wr_mask = 8'hff;
      IDX_OSC_CTL: rcf_wr_mask = 8'h80;
      IDX_PROTECT: rcf_wr_mask = 8'h01;
      IDX_VREG_CTL: rcf_wr_mask = 8'h03;
      IDX_OSC_CTL_TWO: rcf_wr_mask = 8'h03;
      default: rcf_wr_mask = 8'h00;
    endcase
  endfunction

  // Registers locked while the write protect bit is set
  function automatic logic rcf_is_locked(input logic [5:0] idx);
    rcf_is_locked = (idx == IDX_IRC_HIGH) || (idx == IDX_IRC_LOW) ||
      (idx == IDX_OSC_CTL) || (idx == IDX_VREG_CTL) ||
      (idx == IDX_OSC_CTL_TWO);
  endfunction

endpackage

// ==== src/rcf_avmm_slave.sv ====
/*
 Avalon-MM handshake for the register block: one wait cycle per access,
 read data and response registered at the end of the wait cycle.
 Assumes the master holds its request until waitrequest is seen low.
*/
module rcf_avmm_slave (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] rdValue, // Data for a read
  input wire logic rdError, // Access hits no register
  output logic wrFire, // Write lands at this edge
  output logic [31:0] avs_readdata, // Registered read data
  output logic [1:0] avs_response, // Registered response
  output logic avs_waitrequest // Registered wait
);
  import rcf_pkg::*;

  logic request;

  assign request = avs_read | avs_write;

  // Write lands where the master sees waitrequest low
  assign wrFire = avs_write & ~avs_waitrequest;

  // Drop wait for one cycle after a request is seen
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(request & avs_waitrequest);
    end
  end

  // Capture answer together with the wait drop
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      avs_readdata <= '0;
      avs_response <= RESP_OKAY;
    end else if (request && avs_waitrequest) begin
      avs_readdata <= avs_read ? rdValue : '0;
      avs_response <= rdError ? RESP_SLVERR : RESP_OKAY;
    end
  end

endmodule

// ==== src/rcf_cause_flags.sv ====
/*
 The reset cause flag register. Loaded by power-on reset only, set by
 cause events, cleared by writing ones. Ignores the system reset.
 Assumes the power-on level is held for at least one clock edge.
*/
module rcf_cause_flags (
  input wire logic clk_sys, // System clock
  input wire rcf_pkg::rcf_cause_s causeIn, // Cause levels
  input wire logic clrWr, // Software write lands
  input wire logic [7:0] clrData, // Ones clear flags
  output logic [7:0] flags_ff // Flag register
);
  import rcf_pkg::*;

  logic [7:0] setBits;
  logic [7:0] clrBits;
  logic [7:0] nxt_flags;

  // Events mapped onto flag positions
  always_comb begin
    setBits = 8'h00;
    setBits[BIT_LOW_VOLT] = causeIn.lowVoltCore | causeIn.lowVoltNvm |
      causeIn.lowVoltPad;
    setBits[BIT_WATCHDOG] = causeIn.watchdog;
    setBits[BIT_OSC_LOSS] = causeIn.oscLoss;
    setBits[BIT_PLL_LOSS] = causeIn.pllLoss;
  end

  // Clear by ones, set wins over clear
  always_comb begin
    clrBits = clrWr ? (clrData & FLAG_IMPL_MASK) : 8'h00;
    nxt_flags = ((flags_ff & ~clrBits) | setBits) & FLAG_IMPL_MASK;
  end

  // Power-on load; system reset deliberately absent
  always_ff @(posedge clk_sys) begin
    if (causeIn.por) begin
      flags_ff <= FLAG_POR_VALUE;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule

// ==== verification/rcf_monitor.sv ====
/*
 Checker for the reset cause flag block, bound to its top module.
 Assumes power-on cause is held high while nrst is low at start.
*/
module rcf_monitor
  import rcf_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset
  input wire rcf_pkg::rcf_cause_s causeIn, // Causes
  input wire logic [7:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Wait
  input wire logic [7:0] resetFlags // Flags
);
  timeunit 1ns;
  timeprecision 100ps;
  logic flagSel;
  logic clrLand;
  logic [7:0] expClr_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Flag write lands at this edge
  assign flagSel = avs_address[7:2] == 6'h03;
  assign clrLand = avs_write && !avs_waitrequest && flagSel && avs_byteenable[0];
  // Flags after a plain clearing write
  always_ff @(posedge clk_sys) begin
    expClr_ff <= resetFlags & ~avs_writedata[7:0];
  end
  por_load_a:
    assert property (causeIn.por |=> resetFlags == 8'h60) else $error("por load wrong");
  low_volt_a:
    assert property (causeIn[5:3] != 3'h0 |=> resetFlags[5]) else $error("lv not set");
  wdog_set_a:
    assert property (causeIn.watchdog && !causeIn.por |=> resetFlags[3]) else $error("wd");
  osc_set_a:
    assert property (causeIn.oscLoss && !causeIn.por |=> resetFlags[1]) else $error("osc");
  pll_set_a:
    assert property (causeIn.pllLoss && !causeIn.por |=> resetFlags[0]) else $error("pll");
  flag_hold_a:
    assert property (causeIn == 7'h00 && !clrLand |=> $stable(resetFlags))
    else $error("flags moved");
  w1c_clear_a:
    assert property (clrLand && causeIn == 7'h00 |=> resetFlags == expClr_ff)
    else $error("clear wrong");
  unimpl_zero_a:
    assert property ((resetFlags & 8'h94) == 8'h00) else $error("unused bit set");
  flag_read_a:
    assert property (avs_read && avs_waitrequest && flagSel |=>
      avs_readdata == {24'h0, $past(resetFlags)}) else $error("read wrong");
endmodule

bind rcf_reset_cause_flags rcf_monitor rcf_monitor_i (.clk_sys(clk_sys), .nrst(nrst),
  .causeIn(causeIn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .resetFlags(resetFlags));

// ==== verification/rcf_testbench.sv ====
/*
 Self-checking bench for the reset cause flag block over Avalon-MM.
 Assumes one wait cycle per access and power-on cause as flag init.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import rcf_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst;
  rcf_cause_s causeIn;
  logic [7:0] avsAddress;
  logic avsRead, avsWrite, avsWaitrequest;
  logic [3:0] avsByteenable;
  logic [31:0] avsWritedata, avsReaddata;
  logic [1:0] avsResponse, r;
  logic [7:0] resetFlags, q;
  rcf_map_t mapRegs;
  rcf_arm_s armKey;
  int n_fail = 0;
  int comparisons = 0;

  rcf_reset_cause_flags rcf_reset_cause_flags_i (.clk_sys(clk_sys), .nrst(nrst),
    .causeIn(causeIn), .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_byteenable(avsByteenable), .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata), .avs_response(avsResponse),
    .avs_waitrequest(avsWaitrequest), .resetFlags(resetFlags), .mapRegs(mapRegs),
    .armKey(armKey));

  // Clock, 4 ns period
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avsRead <= !wr;
    avsWrite <= wr;
    avsAddress <= a;
    avsWritedata <= {24'h0, d};
    do begin
      @(posedge clk_sys);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata[7:0];
    r = avsResponse;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge clk_sys);
    causeIn <= v;
    @(posedge clk_sys);
    causeIn <= 7'h00;
  endtask

  task automatic t_por;
    bus(1'b0, 8'h0c, 8'h00);
    check(q, 8'h60);
    check({6'h0, r}, 8'h00);
    bus(1'b1, 8'h0c, 8'h00);
    bus(1'b0, 8'h0c, 8'h00);
    check(q, 8'h60);
    bus(1'b1, 8'h0c, 8'h40);
    bus(1'b0, 8'h0c, 8'h00);
    check(q, 8'h20);
    $display("power-on test done");
  endtask

  task automatic t_causes;
    logic [7:0] expv [6] = '{8'h20, 8'h20, 8'h20, 8'h08, 8'h02, 8'h01};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h0c, 8'hff);
      pulse(7'h20 >> i);
      bus(1'b0, 8'h0c, 8'h00);
      check(q, expv[i]);
    end
    pulse(7'h3f);
    bus(1'b0, 8'h0c, 8'h00);
    check(q, 8'h2b);
    $display("cause test done");
  endtask

  task automatic t_sysrst;
    bus(1'b1, 8'h0c, 8'hff);
    pulse(7'h24);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, 8'h0c, 8'h00);
    check(q, 8'h28);
    pulse(7'h40);
    bus(1'b0, 8'h0c, 8'h00);
    check(q, 8'h60);
    $display("system reset test done");
  endtask

  task automatic t_prio;
    causeIn <= 7'h01;
    bus(1'b1, 8'h0c, 8'h61);
    causeIn <= 7'h00;
    bus(1'b0, 8'h0c, 8'h00);
    check(q, 8'h01);
    $display("priority test done");
  endtask

  task automatic t_map;
    bus(1'b1, 8'h50, 8'ha5);
    bus(1'b0, 8'h50, 8'h00);
    check(q, 8'ha5);
    check(mapRegs[IDX_API_HIGH[3:0]], 8'ha5);
    bus(1'b0, 8'h00, 8'h00);
    check({6'h0, r}, 8'h02);
    // Protect bit blocks locked registers
    bus(1'b1, 8'h6c, 8'h01);
    bus(1'b1, 8'h64, 8'hff);
    bus(1'b0, 8'h64, 8'h00);
    check(q, 8'h00);
    check(mapRegs[IDX_IRC_LOW[3:0]], 8'h00);
    check({6'h0, r}, 8'h00);
    bus(1'b1, 8'h6c, 8'h00);
    bus(1'b1, 8'h64, 8'hff);
    bus(1'b0, 8'h64, 8'h00);
    check(q, 8'hff);
    // Arm key strobe lasts one cycle, key held, reads zero
    bus(1'b1, 8'h3c, 8'h5a);
    @(posedge clk_sys);
    check({7'h0, armKey.strobe}, 8'h01);
    check(armKey.key, 8'h5a);
    @(posedge clk_sys);
    check({7'h0, armKey.strobe}, 8'h00);
    bus(1'b0, 8'h3c, 8'h00);
    check(q, 8'h00);
    check({6'h0, r}, 8'h00);
    $display("map test done");
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence, power-on cause held through reset
  initial begin
    nrst = 1'b0;
    causeIn = 7'h40;
    avsAddress = 8'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsByteenable = 4'h1;
    avsWritedata = 32'h0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    causeIn <= 7'h00;
    t_por;
    t_causes;
    t_sysrst;
    t_prio;
    t_map;
    report_and_stop;
  end

  // Hang guard
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    report_and_stop;
  end
endmodule
